// file: hdl/mcr_regs.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "mcr_defs.svh"

// Notes on behaviour
// RQ1: with low power idle set, the device drops to low power whenever all functions idle or wait.
// RQ2: with the bank select bit clear, accesses reach addresses 0x80 and above.
// RQ3: with the bank select bit set, accesses reach addresses 0x60 through 0x74.
// RQ4: with wait extension set, the wait period setting is multiplied by sixteen.
// RQ5: with halt on interrupt set, the oscillator stops while any interrupt is active.
// RQ6: the oscillator halted flag is set whenever the oscillator stops for an interrupt.
// RQ7: the oscillator restarts only after interrupts and the halted flag are both cleared.
// RQ8: the two-bit switch matrix operation field at bits 4:3 resets to 2 and picks the op.
// RQ9: codes are 0 init from defaults, 1 chain to RAM, 2 RAM to chain, 3 reserved.
// RQ10: the host must not change the op field during an operation nor write code 3.
// RQ11: reserved bits 3:0 of the halt config register reset to 0xc, the rest to zero.
// RQ12: the host writes reserved bits back with their reset values by read-modify-write.

module mcr_regs #(
  parameter int WAIT_W = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // device side
  input  wire logic [WAIT_W-1:0] wait_period_setting,
  input  wire logic              irq_active,
  input  wire logic              all_idle,
  input  wire logic              smux_busy,
  input  wire logic [7:0]        host_reg_addr,
  // controls out
  output logic [WAIT_W+3:0]      wait_period_eff,
  output logic                   bank_upper,
  output logic [7:0]             mapped_addr,
  output logic                   mapped_valid,
  output logic [1:0]             switch_matrix_op,
  output logic                   osc_run,
  output logic                   low_power_active,
  output logic                   osc_halted_flag
);

  typedef struct packed {
    logic [7:0]          pwr_cfg;
    logic [7:0]          halt_cfg;
    logic [7:0]          smux_cfg;
    logic                halted;
    logic [31:0]         rdata;
    logic                ready;
    logic                slverr;
    logic [WAIT_W+3:0]   wait_eff;
    logic [7:0]          maddr;
    logic                mvalid;
    logic                run;
    logic                lp;
  } mcr_reg_st_s;

  mcr_reg_st_s r_q, r_d;

  mcr_pkg::mcr_osc_e osc_state;
  logic              halt_event;

  mcr_osc_ctrl i_mcr_osc_ctrl (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .clk_en       (clk_en),
    .halt_on_irq  (r_q.halt_cfg[`MCR_BIT_HALT_ON_IRQ]),
    .low_power_en (r_q.pwr_cfg[`MCR_BIT_LOW_POWER]),
    .irq_active   (irq_active),
    .all_idle     (all_idle),
    .halted_flag  (r_q.halted),
    .state        (osc_state),
    .halt_event   (halt_event)
  );

  logic        acc;
  logic [9:0]  idx;
  logic        addr_ok;
  logic        wr_halted_clr;

  always_comb begin
    r_d           = r_q;
    acc           = psel && penable && !r_q.ready;
    idx           = paddr[11:2];
    addr_ok       = (paddr[1:0] == 2'b00);
    wr_halted_clr = 1'b0;
    r_d.ready     = 1'b0;
    r_d.slverr    = 1'b0;
    if (acc) begin
      r_d.ready = 1'b1;
      r_d.rdata = 32'h0000_0000;
      if (addr_ok && idx == {2'b00, `MCR_IDX_PWR_CFG}) begin
        if (pwrite) begin
          r_d.pwr_cfg = pwdata[7:0];
        end else begin
          r_d.rdata = {24'h00_0000, r_q.pwr_cfg};
        end
      end else if (addr_ok && idx == {2'b00, `MCR_IDX_HALT_CFG}) begin
        if (pwrite) begin
          r_d.halt_cfg = pwdata[7:0];
        end else begin
          r_d.rdata = {24'h00_0000, r_q.halt_cfg};
        end
      end else if (addr_ok && idx == {2'b00, `MCR_IDX_SMUX_CFG}) begin
        if (pwrite) begin
          // busy or reserved code is refused with an error, field kept
          if (smux_busy || pwdata[`MCR_SMUX_OP_HI:`MCR_SMUX_OP_LO] == 2'b11) begin // [RQ10]
            r_d.slverr = 1'b1;
          end else begin
            r_d.smux_cfg = pwdata[7:0]; // [RQ8]
          end
        end else begin
          r_d.rdata = {24'h00_0000, r_q.smux_cfg};
        end
      end else if (addr_ok && idx == {2'b00, `MCR_IDX_STATUS}) begin
        if (pwrite) begin
          wr_halted_clr = pwdata[`MCR_BIT_OSC_HALTED];
        end else begin
          r_d.rdata = {24'h00_0000, 5'h00, osc_state, r_q.halted};
        end
      end else begin
        r_d.slverr = 1'b1;
      end
    end
    // set wins over a simultaneous clear
    if (halt_event) begin
      r_d.halted = 1'b1; // [RQ6]
    end else if (wr_halted_clr) begin
      r_d.halted = 1'b0; // [RQ7]
    end
    if (r_q.pwr_cfg[`MCR_BIT_WAIT_X16]) begin
      r_d.wait_eff = {wait_period_setting, 4'h0}; // [RQ4]
    end else begin
      r_d.wait_eff = {4'h0, wait_period_setting};
    end
    if (r_q.pwr_cfg[`MCR_BIT_BANK_SEL]) begin
      r_d.mvalid = (host_reg_addr >= `MCR_WIN_UP_LO)
                   && (host_reg_addr <= `MCR_WIN_UP_HI); // [RQ3]
    end else begin
      r_d.mvalid = (host_reg_addr >= `MCR_WIN_LOW_LO); // [RQ2]
    end
    r_d.maddr = host_reg_addr;
    r_d.run   = (osc_state != mcr_pkg::MCR_OSC_HALTED); // [RQ5]
    r_d.lp    = (osc_state == mcr_pkg::MCR_OSC_LOW_PWR); // [RQ1]
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_q.pwr_cfg  <= `MCR_RST_PWR_CFG;
      r_q.halt_cfg <= `MCR_RST_HALT_CFG; // [RQ11]
      r_q.smux_cfg <= `MCR_RST_SMUX_CFG; // [RQ8]
      r_q.halted   <= 1'b0;
      r_q.rdata    <= 32'h0000_0000;
      r_q.ready    <= 1'b0;
      r_q.slverr   <= 1'b0;
      r_q.wait_eff <= '0;
      r_q.maddr    <= 8'h00;
      r_q.mvalid   <= 1'b0;
      r_q.run      <= 1'b1;
      r_q.lp       <= 1'b0;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  assign prdata           = r_q.rdata;
  assign pready           = r_q.ready;
  assign pslverr          = r_q.slverr;
  assign wait_period_eff  = r_q.wait_eff;
  assign bank_upper       = r_q.pwr_cfg[`MCR_BIT_BANK_SEL];
  assign mapped_addr      = r_q.maddr;
  assign mapped_valid     = r_q.mvalid;
  assign switch_matrix_op = r_q.smux_cfg[`MCR_SMUX_OP_HI:`MCR_SMUX_OP_LO]; // [RQ9]
  assign osc_run          = r_q.run;
  assign low_power_active = r_q.lp;
  assign osc_halted_flag  = r_q.halted;

  AST_HALT_FLAG: assert property (@(posedge clk) disable iff (sys_rst) // [RQ6]
    clk_en && halt_event |=> osc_halted_flag)
    else $error("halted flag not set on halt");

  AST_NO_RESUME: assert property (@(posedge clk) disable iff (sys_rst) // [RQ7]
    clk_en && osc_state == mcr_pkg::MCR_OSC_HALTED && irq_active
      |=> osc_state == mcr_pkg::MCR_OSC_HALTED || !clk_en)
    else $error("oscillator resumed with interrupt pending");

  AST_HALT_ON_IRQ: assert property (@(posedge clk) disable iff (sys_rst) // [RQ5]
    clk_en && r_q.halt_cfg[4] && irq_active && osc_state == mcr_pkg::MCR_OSC_RUN
      |=> osc_state == mcr_pkg::MCR_OSC_HALTED)
    else $error("oscillator not halted on interrupt");

  AST_WAIT_X16: assert property (@(posedge clk) disable iff (sys_rst) // [RQ4]
    clk_en && r_q.pwr_cfg[`MCR_BIT_WAIT_X16]
      |=> 32'(wait_period_eff) == 32'($past(wait_period_setting)) * 16)
    else $error("wait extension not sixteen");

  AST_WAIT_X1: assert property (@(posedge clk) disable iff (sys_rst) // [RQ4]
    clk_en && !r_q.pwr_cfg[`MCR_BIT_WAIT_X16]
      |=> 32'(wait_period_eff) == 32'($past(wait_period_setting)))
    else $error("wait period changed without extension");

  AST_BANK_LOW: assert property (@(posedge clk) disable iff (sys_rst) // [RQ3]
    clk_en && bank_upper && host_reg_addr == 8'h75 |=> !mapped_valid || !clk_en)
    else $error("address past 0x74 mapped");

  AST_BANK_HIGH: assert property (@(posedge clk) disable iff (sys_rst) // [RQ2]
    clk_en && !bank_upper && host_reg_addr == 8'h80 |=> mapped_valid || !clk_en)
    else $error("address 0x80 not mapped");

  AST_OP_NO_RSV: assert property (@(posedge clk) disable iff (sys_rst) // [RQ10]
    switch_matrix_op != 2'b11)
    else $error("reserved op code stored");

  AST_LOW_PWR: assert property (@(posedge clk) disable iff (sys_rst) // [RQ1]
    clk_en && !r_q.pwr_cfg[5] && osc_state != mcr_pkg::MCR_OSC_LOW_PWR
      |=> osc_state != mcr_pkg::MCR_OSC_LOW_PWR)
    else $error("low power entered while disabled");

  // byte addresses, four times the register index
  localparam logic [11:0] ADDR_HALT = {2'b00, `MCR_IDX_HALT_CFG, 2'b00};
  localparam logic [11:0] ADDR_SMUX = {2'b00, `MCR_IDX_SMUX_CFG, 2'b00};
  localparam logic [11:0] ADDR_STAT = {2'b00, `MCR_IDX_STATUS, 2'b00};

  sequence s_access;
    clk_en && psel && penable && !pready;
  endsequence

  sequence s_wr_smux;
    clk_en && psel && penable && !pready && pwrite && paddr == ADDR_SMUX;
  endsequence

  sequence s_wr_halt;
    clk_en && psel && penable && !pready && pwrite && paddr == ADDR_HALT;
  endsequence

  // a halt event in the same cycle wins, so it is kept out here
  sequence s_clr_flag;
    clk_en && psel && penable && !pready && pwrite && paddr == ADDR_STAT
      && pwdata[`MCR_BIT_OSC_HALTED] && !halt_event;
  endsequence

  sequence s_halt_entry;
    clk_en && osc_state == mcr_pkg::MCR_OSC_RUN
      && r_q.halt_cfg[`MCR_BIT_HALT_ON_IRQ] && irq_active;
  endsequence

  AST_READY_ANS: assert property (@(posedge clk) disable iff (sys_rst) // [RQ12]
    s_access |=> pready)
    else $error("no ready after access phase");

  AST_READY_ONE: assert property (@(posedge clk) disable iff (sys_rst) // [RQ12]
    clk_en && pready |=> !pready)
    else $error("ready held longer than one cycle");

  AST_ERR_READY: assert property (@(posedge clk) disable iff (sys_rst) // [RQ10]
    pslverr |-> pready)
    else $error("error flag without ready");

  AST_HALT_RST: assert property (@(posedge clk) disable iff (sys_rst) // [RQ11]
    $past(sys_rst) |-> r_q.halt_cfg == `MCR_RST_HALT_CFG)
    else $error("halt config reset value wrong");

  AST_OP_RST: assert property (@(posedge clk) disable iff (sys_rst) // [RQ8]
    $past(sys_rst) |-> switch_matrix_op == 2'b10 && !osc_halted_flag)
    else $error("op field or halted flag reset value wrong");

  AST_RMW_KEEP: assert property (@(posedge clk) disable iff (sys_rst) // [RQ12]
    s_wr_halt |=> r_q.halt_cfg == $past(pwdata[7:0]))
    else $error("halt config write not stored as written");

  AST_RSV_REFUSED: assert property (@(posedge clk) disable iff (sys_rst) // [RQ10]
    s_wr_smux ##0 pwdata[`MCR_SMUX_OP_HI:`MCR_SMUX_OP_LO] == 2'b11
      |=> pslverr && $stable(switch_matrix_op))
    else $error("reserved op code write not refused");

  AST_BUSY_REFUSED: assert property (@(posedge clk) disable iff (sys_rst) // [RQ10]
    s_wr_smux ##0 smux_busy |=> pslverr && $stable(switch_matrix_op))
    else $error("op field changed while busy");

  AST_OP_WRITTEN: assert property (@(posedge clk) disable iff (sys_rst) // [RQ8]
    s_wr_smux ##0 (!smux_busy && pwdata[`MCR_SMUX_OP_HI:`MCR_SMUX_OP_LO] != 2'b11)
      |=> switch_matrix_op == $past(pwdata[`MCR_SMUX_OP_HI:`MCR_SMUX_OP_LO]))
    else $error("legal op code not stored");

  AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (sys_rst) // [RQ7]
    s_clr_flag |=> !osc_halted_flag)
    else $error("halted flag not cleared by host");

  AST_FLAG_AFTER: assert property (@(posedge clk) disable iff (sys_rst) // [RQ6]
    s_halt_entry ##1 clk_en |=> osc_halted_flag)
    else $error("halted flag missing after halt entry");

  AST_RUN_LOW: assert property (@(posedge clk) disable iff (sys_rst) // [RQ5]
    s_halt_entry ##1 clk_en |=> !osc_run)
    else $error("oscillator run output high after halt");

  AST_RESUME: assert property (@(posedge clk) disable iff (sys_rst) // [RQ7]
    clk_en && osc_state == mcr_pkg::MCR_OSC_HALTED && !irq_active && !osc_halted_flag
      |=> osc_state == mcr_pkg::MCR_OSC_RUN)
    else $error("oscillator not resumed after both cleared");

  AST_HALT_FROM_LP: assert property (@(posedge clk) disable iff (sys_rst) // [RQ5]
    clk_en && osc_state == mcr_pkg::MCR_OSC_LOW_PWR
      && r_q.halt_cfg[`MCR_BIT_HALT_ON_IRQ] && irq_active
      |=> osc_state == mcr_pkg::MCR_OSC_HALTED)
    else $error("oscillator not halted from low power");

  AST_LP_ENTER: assert property (@(posedge clk) disable iff (sys_rst) // [RQ1]
    clk_en && osc_state == mcr_pkg::MCR_OSC_RUN && r_q.pwr_cfg[`MCR_BIT_LOW_POWER]
      && all_idle && !(r_q.halt_cfg[`MCR_BIT_HALT_ON_IRQ] && irq_active)
      |=> osc_state == mcr_pkg::MCR_OSC_LOW_PWR)
    else $error("low power not entered while idle");

  AST_LP_EXIT: assert property (@(posedge clk) disable iff (sys_rst) // [RQ1]
    clk_en && osc_state == mcr_pkg::MCR_OSC_LOW_PWR && !all_idle
      && !(r_q.halt_cfg[`MCR_BIT_HALT_ON_IRQ] && irq_active)
      |=> osc_state == mcr_pkg::MCR_OSC_RUN)
    else $error("low power kept while busy");

  AST_LP_OUT: assert property (@(posedge clk) disable iff (sys_rst) // [RQ1]
    clk_en && osc_state == mcr_pkg::MCR_OSC_LOW_PWR |=> low_power_active)
    else $error("low power output not raised");

  AST_BANK_UP_IN: assert property (@(posedge clk) disable iff (sys_rst) // [RQ3]
    clk_en && bank_upper && host_reg_addr >= 8'h60 && host_reg_addr <= 8'h74
      |=> mapped_valid)
    else $error("upper window address not mapped");

  AST_BANK_UP_OUT: assert property (@(posedge clk) disable iff (sys_rst) // [RQ3]
    clk_en && bank_upper && (host_reg_addr < 8'h60 || host_reg_addr > 8'h74)
      |=> !mapped_valid)
    else $error("address outside upper window mapped");

  AST_BANK_LOW_OUT: assert property (@(posedge clk) disable iff (sys_rst) // [RQ2]
    clk_en && !bank_upper && host_reg_addr < 8'h80 |=> !mapped_valid)
    else $error("address below 0x80 mapped");

  AST_MADDR: assert property (@(posedge clk) disable iff (sys_rst) // [RQ2]
    clk_en |=> mapped_addr == $past(host_reg_addr))
    else $error("mapped address not a one cycle copy");

endmodule

// file: hdl/mcr_defs.svh
`ifndef MCR_DEFS_SVH
`define MCR_DEFS_SVH

// register offsets (printed offsets not multiples of four: index, byte address = 4*index)
`define MCR_IDX_PWR_CFG      8'ha9
`define MCR_IDX_HALT_CFG     8'hac
`define MCR_IDX_SMUX_CFG     8'haf
`define MCR_IDX_STATUS       8'hb0
// address window bounds picked by the bank select bit
`define MCR_WIN_UP_LO        8'h60
`define MCR_WIN_UP_HI        8'h74
`define MCR_WIN_LOW_LO       8'h80
// field positions
`define MCR_BIT_LOW_POWER    5
`define MCR_BIT_BANK_SEL     4
`define MCR_BIT_WAIT_X16     2
`define MCR_BIT_HALT_ON_IRQ  4
`define MCR_SMUX_OP_LO       3
`define MCR_SMUX_OP_HI       4
`define MCR_BIT_OSC_HALTED   0
// reset values
`define MCR_RST_PWR_CFG      8'h00
`define MCR_RST_HALT_CFG     8'h0c
`define MCR_RST_SMUX_CFG     8'h10
`define MCR_RST_STATUS       8'h00
// wait extension factor as a shift
`define MCR_WAIT_X16_SHIFT   4

`endif

// file: hdl/mcr_pkg.sv
package mcr_pkg;

  typedef enum logic [1:0] {
    MCR_OP_INIT_ROM  = 2'b00,
    MCR_OP_READ_CHN  = 2'b01,
    MCR_OP_WRITE_CHN = 2'b10,
    MCR_OP_RESERVED  = 2'b11
  } mcr_op_e;

  typedef enum logic [1:0] {
    MCR_OSC_RUN     = 2'b00,
    MCR_OSC_HALTED  = 2'b01,
    MCR_OSC_LOW_PWR = 2'b10
  } mcr_osc_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mcr_apb_req_s;

  typedef struct packed {
    logic        osc_run;
    logic        low_power;
    logic        bank_upper;
    logic [11:0] wait_period;
    mcr_op_e     smux_op;
  } mcr_ctrl_s;

endpackage

// file: hdl/mcr_osc_ctrl.sv
`timescale 1ns/1ps
`include "mcr_defs.svh"

module mcr_osc_ctrl (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          clk_en,
  // controls
  input  wire logic          halt_on_irq,
  input  wire logic          low_power_en,
  input  wire logic          irq_active,
  input  wire logic          all_idle,
  input  wire logic          halted_flag,
  // result
  output mcr_pkg::mcr_osc_e  state,
  output logic               halt_event
);

  typedef struct packed {
    mcr_pkg::mcr_osc_e st;
    logic              ev;
  } mcr_osc_st_s;

  mcr_osc_st_s r_q, r_d;

  always_comb begin
    r_d    = r_q;
    r_d.ev = 1'b0;
    case (r_q.st)
      mcr_pkg::MCR_OSC_RUN: begin
        if (halt_on_irq && irq_active) begin // [RQ5]
          r_d.st = mcr_pkg::MCR_OSC_HALTED;
          r_d.ev = 1'b1; // [RQ6]
        end else if (low_power_en && all_idle) begin // [RQ1]
          r_d.st = mcr_pkg::MCR_OSC_LOW_PWR;
        end
      end
      mcr_pkg::MCR_OSC_HALTED: begin
        // both the interrupts and the halted flag must be gone
        if (!irq_active && !halted_flag) begin // [RQ7]
          r_d.st = mcr_pkg::MCR_OSC_RUN;
        end
      end
      mcr_pkg::MCR_OSC_LOW_PWR: begin
        if (halt_on_irq && irq_active) begin // [RQ5]
          r_d.st = mcr_pkg::MCR_OSC_HALTED;
          r_d.ev = 1'b1;
        end else if (!(low_power_en && all_idle)) begin // [RQ1]
          r_d.st = mcr_pkg::MCR_OSC_RUN;
        end
      end
      default: r_d.st = mcr_pkg::MCR_OSC_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_q <= '{st: mcr_pkg::MCR_OSC_RUN, ev: 1'b0};
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  assign state      = r_q.st;
  assign halt_event = r_q.ev;

endmodule

// file: tb/mcr_host_model.sv
`timescale 1ns/1ps
module mcr_host_model (
  // clock
  input  wire logic        clk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready
);
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
  end
  // request held until pready is seen high; once released, the address and data lines show inverted values, pwrite keeps its value
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    // only the bench watchdog ends a wait that never sees ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// file: tb/test_mcr_regs.sv
`timescale 1ns/1ps
module test_mcr_regs;
  logic        clk, sys_rst, clk_en, irq_active, all_idle, smux_busy;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, weff;
  logic [31:0] pwdata, prdata;
  logic [7:0]  wset, host_reg_addr, maddr;
  logic        bank_upper, mapped_valid, osc_run, low_power_active, osc_halted_flag;
  logic [1:0]  switch_matrix_op;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [7:0]  bnd[8] = '{8'h5f, 8'h60, 8'h74, 8'h75, 8'h7f, 8'h80, 8'hff, 8'h00};
  int          err_total, samples_checked;
  localparam logic [11:0] A_PWR = 12'h2a4, A_HALT = 12'h2b0;
  localparam logic [11:0] A_SMUX = 12'h2bc, A_STAT = 12'h2c0;

  mcr_regs #(.WAIT_W(8)) i_mcr_regs (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wait_period_setting(wset),
    .irq_active(irq_active), .all_idle(all_idle), .smux_busy(smux_busy),
    .host_reg_addr(host_reg_addr), .wait_period_eff(weff), .bank_upper(bank_upper),
    .mapped_addr(maddr), .mapped_valid(mapped_valid), .switch_matrix_op(switch_matrix_op),
    .osc_run(osc_run), .low_power_active(low_power_active),
    .osc_halted_flag(osc_halted_flag));
  mcr_host_model i_mcr_host_model (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready));

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // note the expected answer first, then run the bus cycle
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic er, input logic [7:0] x);
    exp_q.push_back({w, er, 24'h0, x});
    i_mcr_host_model.xfer(w, a, d);
  endtask

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected", 1, 0);
      end else begin
        e = exp_q.pop_front();
        chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
        if (!e[33]) chk("prdata", prdata, {24'h0, e[7:0]});
      end
    end
  end

  initial begin
    sys_rst = 1;
    clk_en = 1;
    irq_active = 0;
    all_idle = 0;
    smux_busy = 0;
    wset = 0;
    host_reg_addr = 0;
    void'($urandom(95654));
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    acc(0, A_HALT, 0, 0, 8'h0c);
    acc(0, A_SMUX, 0, 0, 8'h10);
    acc(0, 12'h004, 0, 1, 8'h00);
    for (int x = 0; x < 2; x++) begin
      wset <= 8'($urandom);
      acc(1, A_PWR, {29'h0, x[0], 2'b00}, 0, 0);
      repeat (2) @(posedge clk);
      chk("wait_eff", weff, x[0] ? {wset, 4'h0} : {4'h0, wset});
    end
    // every boundary address in each bank, random addresses in between
    for (int i = 0; i < 32; i++) begin
      if (i == 0 || i == 16) acc(1, A_PWR, {27'h0, i[4], 4'h0}, 0, 0);
      host_reg_addr <= i[0] ? 8'($urandom) : bnd[i[3:1]];
      repeat (2) @(posedge clk);
      chk("bank", bank_upper, i[4]);
      chk("mapped", mapped_valid, i[4] ? (host_reg_addr >= 8'h60 && host_reg_addr <= 8'h74)
                                       : host_reg_addr >= 8'h80);
      chk("maddr", maddr, host_reg_addr);
    end
    for (int k = 0; k < 4; k++) begin
      acc(1, A_SMUX, k * 8, k == 3, 0);
      acc(0, A_SMUX, 0, 0, (k == 3) ? 8'h10 : 8'(k * 8));
      chk("op", switch_matrix_op, (k == 3) ? 2 : k);
    end
    smux_busy <= 1;
    acc(1, A_SMUX, 0, 1, 0);
    smux_busy <= 0;
    acc(0, A_SMUX, 0, 0, 8'h10);
    // halt bit set keeping the reserved reset pattern
    acc(0, A_HALT, 0, 0, 8'h0c);
    acc(1, A_HALT, 32'h1c, 0, 0);
    irq_active <= 1;
    repeat (4) @(posedge clk);
    chk("osc_run", osc_run, 0);
    chk("flag", osc_halted_flag, 1);
    irq_active <= 0;
    repeat (4) @(posedge clk);
    chk("osc_run", osc_run, 0);
    acc(0, A_STAT, 0, 0, 8'h03);
    acc(1, A_STAT, 1, 0, 0);
    repeat (4) @(posedge clk);
    chk("osc_run", osc_run, 1);
    acc(1, A_PWR, 32'h20, 0, 0);
    all_idle <= 1;
    repeat (4) @(posedge clk);
    chk("low_power", low_power_active, 1);
    all_idle <= 0;
    repeat (4) @(posedge clk);
    chk("low_power", low_power_active, 0);
    acc(1, A_SMUX, 0, 0, 0);
    // second reset in mid-run: configuration falls back to its reset values
    sys_rst <= 1;
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    acc(0, A_PWR, 0, 0, 8'h00);
    acc(0, A_HALT, 0, 0, 8'h0c);
    acc(0, A_SMUX, 0, 0, 8'h10);
    chk("flag", osc_halted_flag, 0);
    chk("osc_run", osc_run, 1);
    results;
  end

  // about twenty-four times the expected run length
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    results;
  end
endmodule
